// >>> src/adcgc_defines.svh
`ifndef ADCGC_DEFINES_SVH
`define ADCGC_DEFINES_SVH

`define ADCGC_OFS_SYNC 8'h00
`define ADCGC_OFS_CHOP 8'h04
`define ADCGC_OFS_CONV 8'h08
`define ADCGC_OFS_RCMP 8'h0c
`define ADCGC_OFS_RTHR 8'h10
`define ADCGC_OFS_STAT 8'h14
`define ADCGC_OFS_ICRES 8'h18
`define ADCGC_OFS_ACRES 8'h1c

`define ADCGC_GAIN_MAX 3'h6
`define ADCGC_SYNC_MARGIN 6'h23
`define ADCGC_XING_TICKS 2'h2
`define ADCGC_SETTLE_CNT 2'h2
`define ADCGC_FEED_RST 1'h1

`endif

// >>> src/adcgc_pkg.sv
package adcgc_pkg;

  typedef enum logic [1:0] {
    ADCGC_CHOP_OFF = 2'b00,
    ADCGC_CHOP_FAST = 2'b01,
    ADCGC_CHOP_SLOW = 2'b10,
    ADCGC_CHOP_SW = 2'b11
  } adcgc_chop_e;

  typedef enum logic [1:0] {
    ADCGC_CMD_NONE = 2'b00,
    ADCGC_CMD_IMM = 2'b01,
    ADCGC_CMD_NEXT_IC = 2'b10,
    ADCGC_CMD_NEXT_AC = 2'b11
  } adcgc_cmd_e;

  typedef enum logic [1:0] {
    ADCGC_SYNC_IDLE = 2'b00,
    ADCGC_SYNC_XING = 2'b01,
    ADCGC_SYNC_WAIT = 2'b10
  } adcgc_sst_e;

  // Converter configuration, buffered and active copies
  typedef struct packed {
    logic cadc_en;
    logic vadc_en;
    adcgc_chop_e chop;
    logic pol;
    logic [2:0] gain;
    logic [1:0] ic_dec;
    logic [2:0] ac_dec;
    logic rc_en;
    logic rc_dec_mode;
    logic rc_irq_en;
    logic [7:0] rc_timeout;
    logic [17:0] rc_thresh;
  } adcgc_cfg_s;

  typedef struct packed {
    adcgc_cfg_s shadow;
    adcgc_cfg_s active;
    adcgc_cmd_e cmd;
    adcgc_sst_e st;
    logic [5:0] margin;
    logic [1:0] xcnt;
    logic busy;
    logic conv_rst;
    logic pol;
    logic feed_en;
    logic [1:0] settle;
    logic avg_clr;
    logic [7:0] rc_cnt;
    logic rc_irq;
    logic [15:0] ic_hold;
    logic [17:0] ac_hold;
    logic [31:0] rdata;
  } adcgc_state_s;

endpackage : adcgc_pkg

// >>> src/adcgc_chop_avg.sv
`timescale 1ns/1ns
// Demodulates, optionally averages the last two results, and clamps
module adcgc_chop_avg #(
  parameter int W = 16
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic valid_in,
  input wire logic signed [W:0] data_in,
  input wire logic invert_in,
  input wire logic avg_en_in,
  input wire logic clear_in,
  output logic [W-1:0] result_out,
  output logic valid_out
);

  localparam logic signed [W+1:0] MAXP = {3'b000, {(W-1){1'b1}}};
  localparam logic signed [W+1:0] MINN = {3'b111, {(W-1){1'b0}}};

  typedef struct packed {
    logic signed [W+1:0] prev;
    logic have;
    logic [W-1:0] res;
    logic vld;
  } adcgc_avg_s;

  adcgc_avg_s q;
  adcgc_avg_s next_q;
  logic signed [W+1:0] cur;
  logic signed [W+2:0] sum;

  // Clamp to the result width rather than wrap
  function automatic logic [W-1:0] sat(input logic signed [W+1:0] v);
    if (v > MAXP) return MAXP[W-1:0];
    if (v < MINN) return MINN[W-1:0];
    return v[W-1:0];
  endfunction : sat

  // Running average needs two results; the first after a clear is held back
  always_comb begin
    next_q = q;
    next_q.vld = 1'b0;
    cur = invert_in ? -{data_in[W], data_in} : {data_in[W], data_in};
    sum = {q.prev[W+1], q.prev} + {cur[W+1], cur};
    if (clear_in) begin
      next_q.have = 1'b0;
    end else if (valid_in) begin
      if (avg_en_in) begin
        next_q.prev = cur;
        next_q.have = 1'b1;
        if (q.have) begin
          next_q.res = sat(sum[W+2:1]);
          next_q.vld = 1'b1;
        end
      end else begin
        next_q.res = sat(cur);
        next_q.vld = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign result_out = q.res;
  assign valid_out = q.vld;

endmodule : adcgc_chop_avg

// >>> src/adcgc_ctrl.sv
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "adcgc_defines.svh"
module adcgc_ctrl (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_we_in,
  input wire logic reg_re_in,
  output logic [31:0] reg_rdata_out,
  input wire logic smp_tick_in,
  input wire logic ic_valid_in,
  input wire logic signed [16:0] ic_data_in,
  input wire logic ac_valid_in,
  input wire logic signed [18:0] ac_data_in,
  input wire logic ac_read_busy_in,
  output adcgc_pkg::adcgc_cfg_s conv_cfg_out,
  output logic conv_rst_out,
  output logic polarity_out,
  output logic ac_feed_en_out,
  output logic [15:0] ic_result_out,
  output logic ic_result_valid_out,
  output logic [17:0] ac_result_out,
  output logic ac_result_valid_out,
  output logic rc_irq_out,
  output logic sync_busy_flag_out
);
  import adcgc_pkg::*;

  adcgc_state_s q;
  adcgc_state_s next_q;
  logic apply;
  logic edge_hit;
  logic above;
  logic ic_use;
  logic ic_inv;
  logic ac_inv;
  logic [15:0] ic_avg;
  logic ic_avg_vld;
  logic [17:0] ac_avg;
  logic ac_avg_vld;

  // Code 7 has no gain level, so it folds to the top one
  function automatic logic [2:0] gain_fix(input logic [2:0] g);
    return (g > `ADCGC_GAIN_MAX) ? `ADCGC_GAIN_MAX : g;
  endfunction : gain_fix

  // Magnitude of a signed accumulated result
  function automatic logic [18:0] mag(input logic signed [18:0] v);
    return v[18] ? 19'(-v) : 19'(v);
  endfunction : mag

  function automatic logic auto_mode(input adcgc_chop_e m);
    return (m == ADCGC_CHOP_FAST) || (m == ADCGC_CHOP_SLOW);
  endfunction : auto_mode

  // Only the third result after a fast-mode flip is usable
  assign ic_use = ic_valid_in &&
                  ((q.active.chop != ADCGC_CHOP_FAST) || (q.settle == `ADCGC_SETTLE_CNT));
  assign ic_inv = auto_mode(q.active.chop) && q.pol;
  assign ac_inv = (q.active.chop == ADCGC_CHOP_SLOW) && q.pol;
  assign above = mag(ac_data_in) > {1'b0, q.active.rc_thresh};
  assign edge_hit = ((q.cmd == ADCGC_CMD_NEXT_IC) && ic_valid_in) ||
                    ((q.cmd == ADCGC_CMD_NEXT_AC) && ac_valid_in);

  // Instantaneous path: averaged in fast mode
  adcgc_chop_avg #(
    .W(16)
  ) u_ic_avg (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .valid_in(ic_use),
    .data_in(ic_data_in),
    .invert_in(ic_inv),
    .avg_en_in(q.active.chop == ADCGC_CHOP_FAST),
    .clear_in(q.avg_clr),
    .result_out(ic_avg),
    .valid_out(ic_avg_vld)
  );

  // Accumulated path: averaged in slow mode
  adcgc_chop_avg #(
    .W(18)
  ) u_ac_avg (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .valid_in(ac_valid_in),
    .data_in(ac_data_in),
    .invert_in(ac_inv),
    .avg_en_in(q.active.chop == ADCGC_CHOP_SLOW),
    .clear_in(q.avg_clr),
    .result_out(ac_avg),
    .valid_out(ac_avg_vld)
  );

  // Next-state logic for registers, sync engine, chopper and comparator
  always_comb begin
    next_q = q;
    next_q.conv_rst = 1'b0;
    next_q.avg_clr = 1'b0;
    next_q.rc_irq = 1'b0;
    next_q.rdata = '0;
    apply = 1'b0;

    // Buffered writes, locked while a transfer is pending
    if (reg_we_in && !q.busy) begin
      case (reg_addr_in)
        `ADCGC_OFS_CHOP: begin
          next_q.shadow.chop = adcgc_chop_e'(reg_wdata_in[1:0]);
          next_q.shadow.pol = reg_wdata_in[2];
          next_q.shadow.cadc_en = reg_wdata_in[3];
          next_q.shadow.vadc_en = reg_wdata_in[4];
        end
        `ADCGC_OFS_CONV: begin
          next_q.shadow.gain = gain_fix(reg_wdata_in[2:0]);
          next_q.shadow.ic_dec = reg_wdata_in[5:4];
          next_q.shadow.ac_dec = reg_wdata_in[10:8];
        end
        `ADCGC_OFS_RCMP: begin
          next_q.shadow.rc_en = reg_wdata_in[0];
          next_q.shadow.rc_dec_mode = reg_wdata_in[1];
          next_q.shadow.rc_irq_en = reg_wdata_in[2];
          next_q.shadow.rc_timeout = reg_wdata_in[15:8];
        end
        `ADCGC_OFS_RTHR: begin
          next_q.shadow.rc_thresh = reg_wdata_in[17:0];
        end
        `ADCGC_OFS_SYNC: begin
          if (reg_wdata_in[1:0] != ADCGC_CMD_NONE) begin
            next_q.cmd = adcgc_cmd_e'(reg_wdata_in[1:0]);
            next_q.busy = 1'b1;
            next_q.margin = '0;
            next_q.xcnt = '0;
            // Idle converters have no edge to wait for
            if ((reg_wdata_in[1:0] == ADCGC_CMD_IMM) ||
                (!q.active.cadc_en && !q.active.vadc_en)) begin
              next_q.st = ADCGC_SYNC_XING;
            end else begin
              next_q.st = ADCGC_SYNC_WAIT;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Transfer engine, timed in converter sample cycles
    unique case (q.st)
      ADCGC_SYNC_IDLE: begin
      end
      ADCGC_SYNC_XING: begin
        if (smp_tick_in) begin
          if (q.xcnt == `ADCGC_XING_TICKS - 2'h1) begin
            apply = 1'b1;
          end else begin
            next_q.xcnt = q.xcnt + 2'h1;
          end
        end
      end
      ADCGC_SYNC_WAIT: begin
        if (smp_tick_in && (q.margin < `ADCGC_SYNC_MARGIN)) begin
          next_q.margin = q.margin + 6'h1;
        end
        // A late command lets this edge pass and takes the next one
        if (edge_hit && (q.margin >= `ADCGC_SYNC_MARGIN)) begin
          apply = 1'b1;
        end
      end
      default: begin
        next_q.st = ADCGC_SYNC_IDLE;
      end
    endcase

    // Chopper sequencing on converter results
    unique case (q.active.chop)
      ADCGC_CHOP_FAST: begin
        if (ic_valid_in) begin
          if (q.settle == `ADCGC_SETTLE_CNT) begin
            next_q.settle = '0;
            next_q.pol = !q.pol;
          end else begin
            next_q.settle = q.settle + 2'h1;
          end
        end
      end
      ADCGC_CHOP_SLOW: begin
        if (ac_valid_in) begin
          next_q.pol = !q.pol;
          next_q.settle = '0;
        end else if (ic_valid_in && (q.settle != `ADCGC_SETTLE_CNT)) begin
          next_q.settle = q.settle + 2'h1;
        end
      end
      ADCGC_CHOP_OFF, ADCGC_CHOP_SW: begin
        next_q.settle = `ADCGC_SETTLE_CNT;
      end
    endcase

    // Comparator runs on every accumulated result, readable or not
    if (q.active.rc_en && ac_valid_in) begin
      if (above) begin
        if (q.rc_cnt + 8'h1 >= q.active.rc_timeout) begin
          next_q.rc_cnt = '0;
          next_q.rc_irq = q.active.rc_irq_en;
        end else begin
          next_q.rc_cnt = q.rc_cnt + 8'h1;
        end
      end else if (q.active.rc_dec_mode) begin
        next_q.rc_cnt = (q.rc_cnt != 8'h0) ? q.rc_cnt - 8'h1 : 8'h0;
      end else begin
        next_q.rc_cnt = '0;
      end
    end

    // New settings land; state tied to the old ones is restarted
    if (apply) begin
      next_q.active = q.shadow;
      next_q.busy = 1'b0;
      next_q.st = ADCGC_SYNC_IDLE;
      next_q.cmd = ADCGC_CMD_NONE;
      next_q.conv_rst = (q.cmd == ADCGC_CMD_IMM) ||
                        (!q.active.cadc_en && !q.active.vadc_en);
      if (q.shadow.chop != q.active.chop) begin
        next_q.avg_clr = 1'b1;
        next_q.settle = '0;
        next_q.pol = 1'b0;
      end
      if (q.shadow.rc_dec_mode != q.active.rc_dec_mode) begin
        next_q.rc_cnt = '0;
      end
    end

    // Software mode follows the synchronised select bit only
    // Uses the incoming settings so leaving software mode starts from polarity zero
    if (next_q.active.chop == ADCGC_CHOP_SW) begin
      next_q.pol = next_q.active.pol;
    end
    // Stage two is fed only with settled results
    next_q.feed_en = (next_q.settle == `ADCGC_SETTLE_CNT);

    // Readable copies; a pending readout holds the accumulated one
    if (ic_avg_vld) begin
      next_q.ic_hold = ic_avg;
    end
    if (ac_avg_vld && !ac_read_busy_in) begin
      next_q.ac_hold = ac_avg;
    end

    // Read data stands for exactly one cycle; unmapped reads give zero
    if (reg_re_in) begin
      case (reg_addr_in)
        `ADCGC_OFS_SYNC: next_q.rdata = {29'h0, q.busy, q.cmd};
        `ADCGC_OFS_CHOP: next_q.rdata = {27'h0, q.shadow.vadc_en, q.shadow.cadc_en,
                                         q.shadow.pol, q.shadow.chop};
        `ADCGC_OFS_CONV: next_q.rdata = {21'h0, q.shadow.ac_dec, 2'h0, q.shadow.ic_dec,
                                         1'h0, q.shadow.gain};
        `ADCGC_OFS_RCMP: next_q.rdata = {16'h0, q.shadow.rc_timeout, 5'h0,
                                         q.shadow.rc_irq_en, q.shadow.rc_dec_mode,
                                         q.shadow.rc_en};
        `ADCGC_OFS_RTHR: next_q.rdata = {14'h0, q.shadow.rc_thresh};
        `ADCGC_OFS_STAT: next_q.rdata = {23'h0, q.pol, q.rc_cnt};
        `ADCGC_OFS_ICRES: next_q.rdata = {16'h0, q.ic_hold};
        `ADCGC_OFS_ACRES: next_q.rdata = {14'h0, q.ac_hold};
        default: next_q.rdata = '0;
      endcase
    end
  end

  // Feed enable leaves reset high because the chopper starts off
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      q <= '0;
      q.feed_en <= `ADCGC_FEED_RST;
    end else begin
      q <= next_q;
    end
  end

  // Every output is a state field or a submodule flop
  assign reg_rdata_out = q.rdata;
  assign conv_cfg_out = q.active;
  assign conv_rst_out = q.conv_rst;
  assign polarity_out = q.pol;
  assign ac_feed_en_out = q.feed_en;
  assign ic_result_out = ic_avg;
  assign ic_result_valid_out = ic_avg_vld;
  assign ac_result_out = ac_avg;
  assign ac_result_valid_out = ac_avg_vld;
  assign rc_irq_out = q.rc_irq;
  assign sync_busy_flag_out = q.busy;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  chk_busy_locks_buf: assert property (
    (q.busy && reg_we_in && reg_addr_in == `ADCGC_OFS_CHOP) |=> $stable(q.shadow))
    else $error("buffer changed while sync busy");

  chk_cmd_sets_busy: assert property (
    (!q.busy && reg_we_in && reg_addr_in == `ADCGC_OFS_SYNC && reg_wdata_in[1:0] != 2'h0)
    |=> q.busy throughout (!apply [*2]))
    else $error("sync command did not hold busy");

  chk_gain_legal: assert property (
    q.active.gain <= `ADCGC_GAIN_MAX)
    else $error("active gain code out of range");

  chk_imm_resets: assert property (
    (apply && q.cmd == ADCGC_CMD_IMM) |=> (conv_rst_out && !sync_busy_flag_out))
    else $error("immediate update without converter reset");

  chk_late_deferred: assert property (
    (q.st == ADCGC_SYNC_WAIT && edge_hit && q.margin < `ADCGC_SYNC_MARGIN) |=> q.busy)
    else $error("late command applied on near edge");

  chk_fast_feed: assert property (
    (q.active.chop == ADCGC_CHOP_FAST && !apply && ic_valid_in && q.settle != 2'h1)
    |=> !ac_feed_en_out)
    else $error("settling result fed to stage two");

  chk_slow_drop: assert property (
    (q.active.chop == ADCGC_CHOP_SLOW && !apply && ac_valid_in)
    |=> (!ac_feed_en_out && polarity_out != $past(polarity_out)))
    else $error("slow flip without two dropped results");

  chk_sw_polarity: assert property (
    (q.active.chop == ADCGC_CHOP_SW) |-> polarity_out == q.active.pol)
    else $error("software polarity not followed");

  chk_rc_count_up: assert property (
    (q.active.rc_en && ac_valid_in && above && !apply &&
     (q.rc_cnt + 8'h1 < q.active.rc_timeout)) |=> q.rc_cnt == $past(q.rc_cnt) + 8'h1)
    else $error("counter missed an over-threshold result");

  chk_rc_detect_clr: assert property (
    rc_irq_out |-> (q.rc_cnt == 8'h0 && q.active.rc_irq_en))
    else $error("detection left counter set");

  cov_fast_out: cover property (
    q.active.chop == ADCGC_CHOP_FAST && ic_result_valid_out);
  cov_slow_out: cover property (
    q.active.chop == ADCGC_CHOP_SLOW && ac_result_valid_out);
  cov_deferred: cover property (
    q.st == ADCGC_SYNC_WAIT && apply);
  cov_detect: cover property (rc_irq_out);

endmodule : adcgc_ctrl

// >>> tb/adcgc_conv_model.sv
`timescale 1ns/1ns
// Stand-in for the modulator and decimation chain at the far side
module adcgc_conv_model (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [16:0] ic_val_in,
  input wire logic [18:0] ac_val_in,
  output logic smp_tick_out,
  output logic ic_valid_out,
  output logic ac_valid_out,
  output logic [16:0] ic_data_out,
  output logic [18:0] ac_data_out
);
  logic ph;
  logic [5:0] tcnt;
  logic [1:0] icnt;
  // Tick every other clock, stage 1 every 64 ticks, stage 2 every 4th result
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ph <= 1'b0;
      tcnt <= 6'h00;
      icnt <= 2'h0;
      smp_tick_out <= 1'b0;
      ic_valid_out <= 1'b0;
      ac_valid_out <= 1'b0;
    end else begin
      ph <= ~ph;
      smp_tick_out <= ph;
      ic_valid_out <= ph && tcnt == 6'h3f;
      ac_valid_out <= ph && tcnt == 6'h3f && icnt == 2'h3;
      if (ph) begin
        tcnt <= tcnt + 6'h01;
      end
      if (ph && tcnt == 6'h3f) begin
        icnt <= icnt + 2'h1;
      end
    end
  end
  // Outside a strobe the lines show the inverse, so stale data never matches
  assign ic_data_out = ic_valid_out ? ic_val_in : ~ic_val_in;
  assign ac_data_out = ac_valid_out ? ac_val_in : ~ac_val_in;
endmodule : adcgc_conv_model

// >>> tb/adcgc_ctrl_bench.sv
`timescale 1ns/1ns
module adcgc_ctrl_bench;
  import adcgc_pkg::*;
  logic sys_clk_in, rst_in, we, re, tick, icv, acv, rbusy, crst, pol, feed;
  logic icrv, acrv, irq, busy, seen, ei;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [16:0] icd, icx;
  logic [18:0] acd, acx;
  logic [15:0] icr;
  logic [17:0] acr;
  adcgc_cfg_s cfg;
  int miscompares = 0, checked = 0, seed = 32'h51802cb6;
  int cnt = 0, pend = 0, n, r, a;
  bit chk_on = 0, rc_on = 0, dec = 0, exp_pol = 0;
  bit rc_nx = 0, dec_nx = 0, fast = 0, fast_nx = 0, p = 0, hv = 0;
  int sc = 0, prv = 0, cv = 0;
  logic [31:0] icq[$], acq[$];

  adcgc_conv_model model_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .ic_val_in(icx),
    .ac_val_in(acx), .smp_tick_out(tick), .ic_valid_out(icv), .ac_valid_out(acv),
    .ic_data_out(icd), .ac_data_out(acd));
  adcgc_ctrl dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_we_in(we), .reg_re_in(re), .reg_rdata_out(rdata),
    .smp_tick_in(tick), .ic_valid_in(icv), .ic_data_in(icd), .ac_valid_in(acv),
    .ac_data_in(acd), .ac_read_busy_in(rbusy), .conv_cfg_out(cfg), .conv_rst_out(crst),
    .polarity_out(pol), .ac_feed_en_out(feed), .ic_result_out(icr),
    .ic_result_valid_out(icrv), .ac_result_out(acr), .ac_result_valid_out(acrv),
    .rc_irq_out(irq), .sync_busy_flag_out(busy));

  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  // Random samples; accumulated ones near the threshold half the time, else full scale
  always @(posedge sys_clk_in) begin
    r = $random(seed);
    icx <= r[16:0];
    acx <= r[20] ? r[18:0] : {{9{r[9]}}, r[9:0]};
    rbusy <= r[31];
  end

  function automatic int sat(input int v, input int b);
    int lim;
    lim = (1 << b) - 1;
    return v > lim ? lim : (v < -lim - 1 ? -lim - 1 : v);
  endfunction : sat

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a_in, input logic [31:0] d_in);
    @(posedge sys_clk_in);
    addr <= a_in;
    wdata <= d_in;
    we <= 1'b1;
    @(posedge sys_clk_in);
    we <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a_in, output logic [31:0] d_out);
    @(posedge sys_clk_in);
    addr <= a_in;
    re <= 1'b1;
    @(posedge sys_clk_in);
    re <= 1'b0;
    @(negedge sys_clk_in);
    d_out = rdata;
  endtask : rd

  // Issue a command, try a locked write, wait for busy to drop
  task automatic sync(input logic [1:0] c, input logic rst_exp);
    chk_on = 0;
    @(negedge sys_clk_in);
    chk(busy, 1'b0, "busy before cmd");
    wr(8'h00, {30'h0, c});
    wr(8'h10, 32'h3ffff);
    chk(busy, 1'b1, "busy");
    n = 2;
    while (busy === 1'b1 && n < 2000) begin
      @(negedge sys_clk_in);
      n++;
    end
    chk(busy, 1'b0, "sync timeout");
    chk(crst, rst_exp, "conv reset");
    repeat (3) @(negedge sys_clk_in);
    icq.delete();
    acq.delete();
    cnt = 0;
    chk_on = 1;
  endtask : sync

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // Reference model of results and comparator, checked at every result
  // New settings take hold only once a sync is running, as in the design
  always @(negedge sys_clk_in) begin
    if (busy) begin
      cnt = 0;
      rc_on = rc_nx;
      dec = dec_nx;
      fast = fast_nx;
      sc = 0;
      p = 0;
      hv = 0;
    end
    // Fast mode: two settling results, third demodulated and averaged
    if (icv && fast && !busy) begin
      if (sc == 2) begin
        cv = p ? -$signed(icd) : $signed(icd);
        if (chk_on && hv) icq.push_back({16'h0, 16'(sat((prv + cv) >>> 1, 15))});
        prv = cv;
        hv = 1;
        sc = 0;
        p = !p;
      end else begin
        sc++;
      end
    end else if (chk_on && icv && !fast) begin
      icq.push_back({16'h0, 16'(sat($signed(icd), 15))});
    end
    if (chk_on && acv) acq.push_back({14'h0, 18'(sat($signed(acd), 17))});
    if (chk_on && icrv && icq.size() > 0) chk({16'h0, icr}, icq.pop_front(), "ic");
    if (chk_on && icrv && !fast) chk(pol, exp_pol, "sw polarity");
    if (chk_on && acrv && acq.size() > 0) chk({14'h0, acr}, acq.pop_front(), "ac");
    if (rc_on && acv && !busy) begin
      a = $signed(acd) < 0 ? -$signed(acd) : $signed(acd);
      if (a > 300) cnt++;
      else cnt = (dec && cnt > 0) ? cnt - 1 : 0;
      ei = cnt >= 3;
      if (ei) cnt = 0;
      pend = 3;
      seen = 1'b0;
    end else if (pend > 0) begin
      seen = seen | irq;
      pend--;
      if (pend == 0) chk(seen, ei, "detect");
    end
  end

  initial begin
    #500000;
    miscompares++;
    print_verdict;
  end

  initial begin
    rst_in = 1'b1;
    we = 1'b0;
    re = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    icx = 17'h0;
    acx = 19'h0;
    rbusy = 1'b0;
    repeat (8) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(negedge sys_clk_in);
    chk({busy, feed, irq, crst}, 4'b0100, "reset state");
    wr(8'h08, 32'h217);
    rd(8'h08, d);
    chk(d, 32'h216, "gain clamp");
    rd(8'h20, d);
    chk(d, 32'h0, "unmapped");
    // Software polarity, comparator in clear mode, timeout 3
    wr(8'h04, 32'h0f);
    wr(8'h0c, 32'h305);
    wr(8'h10, 32'h12c);
    exp_pol = 1;
    rc_nx = 1;
    sync(ADCGC_CMD_IMM, 1'b1);
    chk(n <= 8, 1'b1, "both-off latency");
    chk({cfg.chop, cfg.gain, pol}, {ADCGC_CHOP_SW, 3'h6, 1'b1}, "applied cfg");
    rd(8'h10, d);
    chk(d, 32'h12c, "locked write");
    repeat (20000) @(posedge sys_clk_in);
    // Change to decrement mode
    wr(8'h0c, 32'h307);
    dec_nx = 1;
    sync(ADCGC_CMD_IMM, 1'b1);
    repeat (20000) @(posedge sys_clk_in);
    rc_nx = 0;
    rc_on = 0;
    // Deferred update waits for the 35-tick margin and an IC edge
    exp_pol = 0;
    wr(8'h04, 32'h0b);
    sync(ADCGC_CMD_NEXT_IC, 1'b0);
    chk(n >= 70, 1'b1, "deferred margin");
    chk({cfg.pol, pol}, 2'b00, "deferred pol");
    // Deferred update on the next accumulated edge
    exp_pol = 1;
    wr(8'h04, 32'h0f);
    sync(ADCGC_CMD_NEXT_AC, 1'b0);
    chk(n >= 70, 1'b1, "accum margin");
    chk({cfg.pol, pol}, 2'b11, "accum pol");
    repeat (1000) @(posedge sys_clk_in);
    // Leave software mode for fast chopping, immediately as advised
    wr(8'h04, 32'h09);
    fast_nx = 1;
    sync(ADCGC_CMD_IMM, 1'b1);
    chk(cfg.chop, ADCGC_CHOP_FAST, "fast cfg");
    repeat (3000) @(posedge sys_clk_in);
    print_verdict;
  end
endmodule : adcgc_ctrl_bench
